// ==== design/clrc_cfg.svh ====
// Constants for the lock and control register bank
`ifndef CLRC_CFG_SVH
`define CLRC_CFG_SVH

`define CLRC_ADDR_LOCK 8'h00
`define CLRC_ADDR_CONTROL 8'h01
`define CLRC_UNLOCK_KEY 8'h95
`define CLRC_LOCK_RESET 8'h00
`define CLRC_CONTROL_RESET 8'h08
`define CLRC_CONTROL_WMASK 8'h19
`define CLRC_ERROR_FORCE_FIELD_HI 4
`define CLRC_ERROR_FORCE_FIELD_LO 3
`define CLRC_RST_BIT 0
`define CLRC_ERROR_FORCE_FIELD_NOP 2'h0
`define CLRC_ERROR_FORCE_FIELD_SET 2'h1
`define CLRC_ERROR_FORCE_FIELD_CLEAR 2'h2
`define CLRC_CODE_RESET 16'h0000
`define CLRC_ERR_LOW_BYTE 8'h00

`endif

// ==== design/clrc_pkg.sv ====
// Types for the lock and control register bank
package clrc_pkg;

    typedef struct packed {
        logic valid;
        logic tag;
        logic [15:0] payload;
    } clrc_frame_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } clrc_cfg_write_t;

    typedef struct packed {
        logic [7:0] lock_key;
        logic [7:0] control;
        logic error;
        logic [15:0] code;
        clrc_cfg_write_t fwd;
    } clrc_state_t;

    typedef struct packed {
        logic [15:0] code;
    } clrc_out_state_t;

endpackage

// ==== design/clrc_output_select.sv ====
// Output code selection between the live code and the fault level
`include "clrc_cfg.svh"

module clrc_output_select
    import clrc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire logic i_error,
    input wire logic [15:0] i_code,
    input wire logic i_fault_level_select,
    input wire logic [7:0] i_err_low,
    input wire logic [7:0] i_err_high,
    output logic [15:0] o_output_code
);

    clrc_out_state_t state;
    clrc_out_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        if (i_error) begin
            next_state.code = {(i_fault_level_select ? i_err_high : i_err_low), `CLRC_ERR_LOW_BYTE};
        end else begin
            next_state.code = i_code;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= '{code: `CLRC_CODE_RESET};
        end else if (i_clk_en) begin
            state <= next_state;
        end
    end

    assign o_output_code = state.code;

endmodule

// ==== design/clrc_lock_control.sv ====
// Lock register and first control register of the serial-fed converter
// Functional notes
// - Writing the unlock key to the lock register unlocks configuration.
// - Writing any other value to the lock register locks again.
// - Locked: configuration-frame writes to configuration registers are ignored.
// - Unlocked: output-code frames are not applied to the output.
// - Error-force field: 01 sets error, 10 clears, 00 and 11 do nothing.
// - Error-force field self-clears after acting.
// - Error condition is asserted from power-on until cleared.
// - A valid frame clears the error condition unless a pending set force, i_error_set or the reset bit acts in the same cycle.
// - Reset bit one restores the bank defaults like power-on, the output-select code register excepted; zero does nothing.
// - Reset bit clears itself once defaults are restored.
// - Tag one frame: address byte then data byte, MSB first.
// - Tag zero frame: sixteen-bit output code word.
// - In error, output is fault level byte over a zero low byte.
`include "clrc_cfg.svh"

module clrc_lock_control
    import clrc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire clrc_frame_t i_frame,
    input wire logic i_error_set,
    input wire logic i_fault_level_select,
    input wire logic [7:0] i_err_low,
    input wire logic [7:0] i_err_high,
    output logic [7:0] o_config_lock_key,
    output logic [7:0] o_error_force_and_reset_control,
    output logic o_unlocked,
    output logic o_error,
    output logic o_soft_reset,
    output clrc_cfg_write_t o_cfg_write,
    output logic [15:0] o_output_code_word,
    output logic [15:0] o_output_code
);

    clrc_state_t state;
    clrc_state_t next_state;
    logic [7:0] f_addr;
    logic [7:0] f_data;
    logic [1:0] error_force_field;

    function automatic logic is_unlocked(input logic [7:0] key);
        return key == `CLRC_UNLOCK_KEY;
    endfunction

    function automatic clrc_state_t defaults();
        clrc_state_t d;
        d.lock_key = `CLRC_LOCK_RESET;
        d.control = `CLRC_CONTROL_RESET;
        d.error = 1'b1;
        d.code = `CLRC_CODE_RESET;
        d.fwd = '0;
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    assign f_addr = i_frame.payload[15:8];
    assign f_data = i_frame.payload[7:0];
    assign error_force_field = state.control[`CLRC_ERROR_FORCE_FIELD_HI:`CLRC_ERROR_FORCE_FIELD_LO];

    always_comb begin
        next_state = state;
        next_state.fwd = '0;
        if (state.control[`CLRC_RST_BIT]) begin
            // Bank back to defaults, reset bit included, the output-select code register excepted
            next_state = defaults();
        end else begin
            if (i_frame.valid) begin
                next_state.error = 1'b0;
                if (i_frame.tag) begin
                    if (f_addr == `CLRC_ADDR_LOCK) begin
                        next_state.lock_key = f_data;
                    end else if (is_unlocked(state.lock_key)) begin
                        if (f_addr == `CLRC_ADDR_CONTROL) begin
                            // Reserved bits held at zero whatever the master sends
                            next_state.control = f_data & `CLRC_CONTROL_WMASK;
                        end else begin
                            next_state.fwd = '{valid: 1'b1, addr: f_addr, data: f_data};
                        end
                    end
                end else if (!is_unlocked(state.lock_key)) begin
                    next_state.code = i_frame.payload;
                end
            end
            // A pending force acts after the frame clear, so a set survives
            if (error_force_field == `CLRC_ERROR_FORCE_FIELD_SET) begin
                next_state.error = 1'b1;
            end else if (error_force_field == `CLRC_ERROR_FORCE_FIELD_CLEAR) begin
                next_state.error = 1'b0;
            end
            if (!(i_frame.valid && i_frame.tag && f_addr == `CLRC_ADDR_CONTROL && is_unlocked(state.lock_key))) begin
                next_state.control[`CLRC_ERROR_FORCE_FIELD_HI:`CLRC_ERROR_FORCE_FIELD_LO] = `CLRC_ERROR_FORCE_FIELD_NOP;
            end
            // Other error sources win over any clear in the same cycle
            if (i_error_set) begin
                next_state.error = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= defaults();
        end else if (i_clk_en) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_config_lock_key = state.lock_key;
    assign o_error_force_and_reset_control = state.control;
    assign o_unlocked = is_unlocked(state.lock_key);
    assign o_error = state.error;
    assign o_soft_reset = state.control[`CLRC_RST_BIT] & i_clk_en;
    assign o_cfg_write = state.fwd;
    assign o_output_code_word = state.code;

    clrc_output_select u_output_select (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .i_error(state.error),
        .i_code(state.code),
        .i_fault_level_select(i_fault_level_select),
        .i_err_low(i_err_low),
        .i_err_high(i_err_high),
        .o_output_code(o_output_code)
    );

endmodule

// ==== sim/clrc_master_model.sv ====
// Link master model that hands decoded frames to the bank
module clrc_master_model
    import clrc_pkg::*;
(
    input wire logic i_clock,
    output clrc_frame_t o_frame
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_frame = '0;
    // Idle payload inverts, so a stale frame is never reused
    task automatic send(input logic tag, input logic [15:0] p);
        @(posedge i_clock);
        #1 o_frame = {1'b1, tag, p};
        @(posedge i_clock);
        #1 o_frame = {1'b0, tag, ~p};
    endtask
endmodule

// ==== sim/clrc_lock_control_asserts.sv ====
// Checker for the lock and control register bank
module clrc_lock_control_asserts
    import clrc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire clrc_frame_t i_frame,
    input wire logic i_error_set,
    input wire logic [7:0] o_config_lock_key,
    input wire logic [7:0] o_error_force_and_reset_control,
    input wire logic o_unlocked,
    input wire logic o_error,
    input wire logic o_soft_reset,
    input wire logic [15:0] o_output_code_word
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    wire fv = i_frame.valid && i_clk_en;
    wire [7:0] ad = i_frame.payload[15:8];
    wire [7:0] ctl = o_error_force_and_reset_control;
    ////////////////////////////////////////////////////////////////
    AST_UNLOCK: assert property (fv && !ctl[0] && i_frame.tag && i_frame.payload == 16'h0095 |=> o_unlocked)
        else $error("unlock key not taken");
    AST_RELOCK: assert property (fv && i_frame.tag && ad == 8'h00 && i_frame.payload[7:0] != 8'h95 |=> !o_unlocked)
        else $error("lock not restored");
    AST_LOCKED_CFG: assert property (fv && i_frame.tag && ad == 8'h01 && !o_unlocked && ctl == 8'h00 |=> ctl == 8'h00)
        else $error("locked control write applied");
    AST_HOLD_CODE: assert property (fv && !ctl[0] && !i_frame.tag && o_unlocked |=> $stable(o_output_code_word))
        else $error("code applied while unlocked");
    AST_CODE: assert property (fv && !ctl[0] && !i_frame.tag && !o_unlocked |=> o_output_code_word == $past(i_frame.payload))
        else $error("code word not stored");
    AST_ERROR_FORCE_FIELD_SET: assert property (i_clk_en && ctl[4:3] == 2'h1 && !ctl[0] |=> o_error)
        else $error("set error not applied");
    AST_ERROR_FORCE_FIELD_CLR: assert property (i_clk_en && ctl[4:3] == 2'h2 && !ctl[0] && !i_error_set |=> !o_error)
        else $error("clear error not applied");
    AST_SELF_CLR: assert property (i_clk_en && ctl[4:3] != 2'h0 && !ctl[0] && !fv |=> ctl[4:3] == 2'h0)
        else $error("error force field stuck");
    AST_FRAME_CLR: assert property (fv && !i_error_set && ctl[4:3] != 2'h1 && !ctl[0] |=> !o_error)
        else $error("frame did not clear error");
    AST_SOFT_RST: assert property (o_soft_reset && i_clk_en |=> o_config_lock_key == 8'h00 && ctl == 8'h08 && o_error)
        else $error("soft reset defaults wrong");
endmodule
bind clrc_lock_control clrc_lock_control_asserts u_chk (.*);

// ==== sim/tb_config_lock_and_control_regs.sv ====
// Scenario testbench for the lock and control register bank
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    $display("Error %s expected %h seen %h", n, e, a); n_mismatch++; end end
module tb_config_lock_and_control_regs;
    import clrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst_b = 0, err_set = 0, sel = 0;
    clrc_cfg_write_t fwd;
    int n_mismatch = 0, samples_checked = 0;
    clrc_frame_t frame;
    logic [7:0] lock, ctl;
    logic unl, err, srst;
    logic [15:0] word, code;
    always #25 i_clock = ~i_clock;
    clrc_master_model MM (.i_clock(i_clock), .o_frame(frame));
    clrc_lock_control DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(1'b1), .i_frame(frame),
        .i_error_set(err_set), .i_fault_level_select(sel), .i_err_low(8'h24), .i_err_high(8'hE8),
        .o_config_lock_key(lock), .o_error_force_and_reset_control(ctl), .o_unlocked(unl),
        .o_error(err), .o_soft_reset(srst), .o_cfg_write(fwd), .o_output_code_word(word), .o_output_code(code));
    task automatic tick();
        @(posedge i_clock);
        #1;
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        tick();
        `CHK("ctl", 8'h08, ctl)
        `CHK("err", 1'b1, err)
        tick();
        i_rst_b = 1;
        tick();
        `CHK("ctl", 8'h00, ctl)
    endtask
    task automatic t_code();
        MM.send(0, 16'h1234);
        `CHK("word", 16'h1234, word)
        `CHK("err", 1'b0, err)
        tick();
        `CHK("code", 16'h1234, code)
        MM.send(1, 16'h0095);
        `CHK("unl", 1'b1, unl)
        MM.send(0, 16'h5555);
        `CHK("word", 16'h1234, word)
    endtask
    task automatic t_error_force_field();
        MM.send(1, 16'h0108);
        tick();
        `CHK("err", 1'b1, err)
        `CHK("ctl", 8'h00, ctl)
        MM.send(1, 16'h0118);
        `CHK("ctl", 8'h18, ctl)
        tick();
        `CHK("err", 1'b0, err)
        MM.send(1, 16'h0000);
        `CHK("unl", 1'b0, unl)
        MM.send(1, 16'h0108);
        tick();
        `CHK("err", 1'b0, err)
        err_set = 1;
        tick();
        err_set = 0;
        tick();
        `CHK("code", 16'h2400, code)
        sel = 1;
        tick();
        `CHK("code", 16'hE800, code)
        sel = 0;
    endtask
    task automatic t_soft();
        MM.send(1, 16'h0095);
        MM.send(1, 16'h0207);
        `CHK("fwd", 17'h10207, fwd)
        tick();
        `CHK("fwd", 1'b0, fwd.valid)
        MM.send(1, 16'h0101);
        `CHK("srst", 1'b1, srst)
        tick();
        `CHK("lock", 8'h00, lock)
        `CHK("ctl", 8'h08, ctl)
        `CHK("err", 1'b1, err)
    endtask
    initial begin
        t_reset();
        t_code();
        t_error_force_field();
        t_soft();
        conclude();
    end
    // Whole run needs a few dozen cycles
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule
